// >>> led_driver_fault_manager.sv
`timescale 1ns/1ns
// Summary of operation
// - fault pin is open drain, pulled low while a reportable fault is held.
// - group mode: external low over 8 switching cycles stops boost and sinks.
// - a sink above the short threshold leaves regulation.
// - standard mode: short flags fault, only that channel is disabled.
// - latched fault holds until enable or dimming is low over 16 ms.
// - group mode: any short outside overvoltage wait turns off all strings and latches the fault.
// - short detection armed only while some sink sits in regulation.
// - with every sink above regulation, no shorts flagged, channels run.
// - overvoltage alone is not latched, no fault, only halts switching.
// - standard soft start overvoltage drops unregulated strings, flags fault.
// - after overvoltage stop, switching resumes once output has dropped.
// - group soft start overvoltage with unregulated string latches all off.
// - standard run overvoltage drops zero-current string, resumes others.
// - group mode: a string opening in operation latches all strings off.
// - current over primary limit ends the present on-time at once.
// - enable high and dimming low over 16 ms clears latched state.
// - next cycle after a current-limited one starts normally, no latch.
module led_driver_fault_manager
  import fault_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // static configuration strap, 1 selects group shutdown
  input wire logic group_mode_strap,
  // control pins from the system controller
  input wire logic enable_pin,
  input wire logic dim_pin,
  // comparator outputs, asynchronous to clk
  input wire logic [NUM_CH-1:0] string_short_threshold,
  input wire logic [NUM_CH-1:0] sink_in_regulation,
  input wire logic [NUM_CH-1:0] sink_zero_current,
  input wire logic overvoltage_sense,
  input wire logic overvoltage_released,
  input wire logic current_limit_sense,
  input wire logic soft_start,
  // one-cycle pulse at the start of each switching cycle
  input wire logic switching_cycle_rate,
  // shared open-drain fault line
  input wire logic fault_line_in,
  output logic fault_line_out,
  output logic fault_line_oe,
  // controls to the power stage
  output logic [NUM_CH-1:0] sink_enable,
  output logic boost_enable,
  output logic on_time_end
);
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_OV_WAIT = 3'h2,
    ST_LATCHED = 3'h4
  } mode_e;

  logic [NUM_CH-1:0] short_s;
  logic [NUM_CH-1:0] reg_s;
  logic [NUM_CH-1:0] zero_s;
  logic ov_s, ovrel_s, ilim_s, ss_s, en_s, dim_s, line_s;
  logic group_q;
  logic fault_q;
  logic [NUM_CH-1:0] ch_off_q;
  mode_e state_q;
  logic [RESET_CNT_W-1:0] hold_cnt_q;
  logic clear_fault;
  logic [3:0] ext_cnt_q;
  logic ext_trip;
  logic short_armed;
  logic [NUM_CH-1:0] short_hits;
  logic ov_open;
  logic ov_cut;

  // every pin input except the strap and switching_cycle_rate passes two flops before use
  sync_stage #(.W(3 * NUM_CH + 7)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({string_short_threshold, sink_in_regulation,
      sink_zero_current, overvoltage_sense, overvoltage_released,
      current_limit_sense, soft_start, enable_pin, dim_pin,
      fault_line_in}),
    .sync_out({short_s, reg_s, zero_s, ov_s, ovrel_s, ilim_s, ss_s,
      en_s, dim_s, line_s})
  );

  // strap caught by a clocked process while reset is asserted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      group_q <= group_mode_strap;
    end
  end

  // low-hold timer on enable or dimming; clears latched state
  always_ff @(posedge clk) begin
    if (sys_rst || (en_s && dim_s)) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q != RESET_CNT_W'(RESET_HOLD)) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end
  assign clear_fault = (hold_cnt_q == RESET_CNT_W'(RESET_HOLD));

  // count switching cycles the shared line is held low by another party;
  // our own pull is excluded so we do not trip on our own report
  always_ff @(posedge clk) begin
    if (sys_rst || line_s || fault_q || !group_q) begin
      ext_cnt_q <= '0;
    end else if (switching_cycle_rate && ext_cnt_q <= EXT_FAULT_CYC) begin
      ext_cnt_q <= ext_cnt_q + 1'b1;
    end
  end
  assign ext_trip = (ext_cnt_q > EXT_FAULT_CYC);

  // short detection only when some sink regulates
  assign short_armed = |reg_s;
  assign short_hits = short_armed ? short_s : CH_NONE;
  assign ov_open = ss_s ? |(~reg_s & ~ch_off_q) :
    |(zero_s & ~ch_off_q);

  // fault flag and channel disables; set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_q <= 1'b0;
      ch_off_q <= CH_NONE;
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (group_q && (|short_hits || (ov_s && ov_open))) begin
            fault_q <= 1'b1;
            ch_off_q <= CH_ALL_ON;
            state_q <= ST_LATCHED;
          end else if (group_q && ext_trip) begin
            ch_off_q <= CH_ALL_ON;
            state_q <= ST_LATCHED;
          end else begin
            if (|short_hits) begin
              fault_q <= 1'b1;
              ch_off_q <= ch_off_q | short_hits;
            end else if (clear_fault) begin
              fault_q <= 1'b0;
              ch_off_q <= CH_NONE;
            end
            if (ov_s) begin
              state_q <= ST_OV_WAIT;
              if (ss_s) begin
                ch_off_q <= ch_off_q | short_hits | ~reg_s;
                if (ov_open) begin
                  fault_q <= 1'b1;
                end
              end else begin
                ch_off_q <= ch_off_q | short_hits | zero_s;
              end
            end
          end
        end
        ST_OV_WAIT: begin
          if (|short_hits) begin
            fault_q <= 1'b1;
            ch_off_q <= ch_off_q | short_hits;
          end
          if (ovrel_s && !ov_s) begin
            state_q <= ST_RUN;
          end
        end
        ST_LATCHED: begin
          // only the long low hold releases a latched-off device;
          // a short still present keeps it latched, so set wins
          if (clear_fault && !(|short_hits)) begin
            fault_q <= 1'b0;
            ch_off_q <= CH_NONE;
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // boost halted while waiting out overvoltage or latched off
  assign ov_cut = (state_q != ST_RUN) || ov_s;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boost_enable <= 1'b0;
      sink_enable <= CH_NONE;
    end else begin
      boost_enable <= !ov_cut && (state_q != ST_LATCHED);
      sink_enable <= ~ch_off_q;
    end
  end

  // per-cycle limit: combinational, never latched, next cycle unaffected
  assign on_time_end = ilim_s;

  // open drain: drive low only while a fault is held
  assign fault_line_out = 1'b0;
  assign fault_line_oe = fault_q;
endmodule

// >>> fault_pkg.sv
package fault_pkg;
  localparam int NUM_CH = 6;
  // reset-timer length in ms, converted to 25 MHz clock cycles
  localparam int CLK_HZ = 25000000;
  localparam int RESET_HOLD_MS = 16;
  localparam int RESET_HOLD_CYC = CLK_HZ / 1000 * RESET_HOLD_MS;
  localparam int RESET_CNT_W = 20;
  // fault line must be low for more than this many switching cycles
  localparam logic [3:0] EXT_FAULT_CYC = 4'h8;
  localparam logic [NUM_CH-1:0] CH_ALL_ON = 6'h3F;
  localparam logic [NUM_CH-1:0] CH_NONE = 6'h00;
endpackage

// >>> sync_stage.sv
`timescale 1ns/1ns
// two-flop synchroniser for a vector of asynchronous levels
module sync_stage #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> led_driver_fault_manager_props.sv
`timescale 1ns/1ns
// sync delay of the pins is covered by short delay ranges
module led_driver_fault_manager_props
  import fault_pkg::*;
#(
  parameter int RESET_HOLD = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins in
  input wire logic group_mode_strap,
  input wire logic enable_pin,
  input wire logic dim_pin,
  input wire logic [NUM_CH-1:0] string_short_threshold,
  input wire logic [NUM_CH-1:0] sink_in_regulation,
  input wire logic overvoltage_sense,
  input wire logic overvoltage_released,
  input wire logic current_limit_sense,
  // pins out
  input wire logic fault_line_out,
  input wire logic fault_line_oe,
  input wire logic boost_enable,
  input wire logic on_time_end
);
  int clr_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // counted at the pins, so it runs ahead of the design's own count
  always_ff @(posedge clk) begin
    clr_q <= (sys_rst || (enable_pin && dim_pin)) ? 0 : clr_q + 1;
  end
  // no sink at regulation voltage, so short detection must stay disarmed
  sequence s_unarmed;
    sink_in_regulation == 6'h00;
  endsequence
  a_line_only_low: assert property (fault_line_out == 1'b0)
    else $error("fault line driven high");
  a_short_flags: assert property ($rose(|string_short_threshold)
    && |sink_in_regulation |-> ##[2:4] fault_line_oe)
    else $error("short not reported");
  // the first cycles flush any short caught while still armed
  a_no_arm_low: assert property (s_unarmed [*3]
    ##1 (s_unarmed and !fault_line_oe) ##1 s_unarmed [*8]
    |-> !fault_line_oe)
    else $error("fault set while unarmed");
  a_hold_fault: assert property (fault_line_oe && clr_q < RESET_HOLD
    |=> fault_line_oe)
    else $error("fault dropped early");
  a_clear_release: assert property (clr_q == RESET_HOLD + 6
    |-> !fault_line_oe)
    else $error("fault not cleared");
  a_ov_halts_boost: assert property ($rose(overvoltage_sense)
    |-> ##[1:4] !boost_enable)
    else $error("boost kept on");
  a_ov_resume: assert property ($fell(overvoltage_sense)
    && overvoltage_released && !group_mode_strap |-> ##[2:6] boost_enable)
    else $error("boost not resumed");
  a_limit_trunc: assert property ($rose(current_limit_sense)
    |-> ##[1:3] on_time_end)
    else $error("on time not ended");
  a_limit_free: assert property ($fell(current_limit_sense)
    |-> ##[1:3] !on_time_end)
    else $error("limit held over");
endmodule

// >>> fault_line_model.sv
`timescale 1ns/1ns
// shared fault line: pull-up, any party may pull it low
module fault_line_model (
  // pull-low requests
  input wire logic dut_oe,
  input wire logic peer_pull,
  // resulting level
  output logic line
);
  // wired-AND, so a peer can hold it low however long it likes
  assign line = !(dut_oe || peer_pull);
endmodule

// >>> led_driver_fault_manager_bench.sv
`timescale 1ns/1ns
module led_driver_fault_manager_bench;
  import fault_pkg::*;
  localparam int RH = 50;
  logic clk = 0, sys_rst = 1, strap = 0, en = 1, dim = 1, ov = 0, ovr = 0;
  logic cl = 0, sw = 0, ext = 0, line, oe, out, bst, ote;
  logic [NUM_CH-1:0] sh = 6'h00, rg = 6'h3F, se, zc = 6'h00;
  logic ss = 0;
  int error_cnt = 0, total_checks = 0;
  // zero current and soft start drive the overvoltage cases
  led_driver_fault_manager #(.RESET_HOLD(RH)) led_driver_fault_manager_i (
    .clk(clk), .sys_rst(sys_rst), .group_mode_strap(strap),
    .enable_pin(en), .dim_pin(dim), .string_short_threshold(sh),
    .sink_in_regulation(rg), .sink_zero_current(zc),
    .overvoltage_sense(ov), .overvoltage_released(ovr),
    .current_limit_sense(cl), .soft_start(ss),
    .switching_cycle_rate(sw), .fault_line_in(line),
    .fault_line_out(out), .fault_line_oe(oe), .sink_enable(se),
    .boost_enable(bst), .on_time_end(ote));
  fault_line_model fault_line_model_i (.dut_oe(oe), .peer_pull(ext),
    .line(line));
  always #20 clk = ~clk;
  // one-cycle switching pulse every other clock
  always @(posedge clk) sw <= #1 !sw;
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rst(input logic g);
    strap = g;
    sys_rst = 1;
    w(6);
    sys_rst = 0;
    w(2);
  endtask
  task clr(input logic by_en);
    if (by_en) en = 0;
    else dim = 0;
    w(RH + 10);
    en = 1;
    dim = 1;
    w(4);
  endtask
  task t_short;
    rg = 6'h01;
    sh = 6'h04;
    w(6);
    chk(oe, 8'h01);
    chk(se, 8'h3B);
    sh = 6'h00;
    w(20);
    chk(oe, 8'h01);
    clr(0);
    chk(oe, 8'h00);
    chk(se, 8'h3F);
    $display("t_short done");
  endtask
  task t_unarmed;
    rg = 6'h00;
    w(4);
    sh = 6'h3F;
    w(10);
    chk(oe, 8'h00);
    chk(se, 8'h3F);
    sh = 6'h00;
    rg = 6'h01;
    $display("t_unarmed done");
  endtask
  task t_ov_cl;
    ov = 1;
    w(5);
    chk(bst, 8'h00);
    chk(oe, 8'h00);
    ov = 0;
    ovr = 1;
    w(7);
    chk(bst, 8'h01);
    ovr = 0;
    cl = 1;
    w(3);
    chk(ote, 8'h01);
    cl = 0;
    w(3);
    chk(ote, 8'h00);
    chk(oe, 8'h00);
    $display("t_ov_cl done");
  endtask
  task t_ov_ss;
    ss = 1;
    rg = 6'h3D;
    ov = 1;
    w(6);
    chk(oe, 8'h01);
    chk(se, 8'h3D);
    ov = 0;
    ovr = 1;
    ss = 0;
    w(7);
    chk(bst, 8'h01);
    ovr = 0;
    rg = 6'h3F;
    clr(1);
    chk(oe, 8'h00);
    chk(se, 8'h3F);
    zc = 6'h04;
    ov = 1;
    w(6);
    chk(se, 8'h3B);
    chk(oe, 8'h00);
    ov = 0;
    ovr = 1;
    zc = 6'h00;
    w(7);
    chk(bst, 8'h01);
    ovr = 0;
    clr(1);
    chk(se, 8'h3F);
    $display("t_ov_ss done");
  endtask
  task t_group;
    rst(1);
    ext = 1;
    w(10);
    chk(se, 8'h3F);
    w(20);
    chk(se, 8'h00);
    chk(bst, 8'h00);
    ext = 0;
    clr(1);
    chk(se, 8'h3F);
    sh = 6'h04;
    w(6);
    chk(se, 8'h00);
    chk(oe, 8'h01);
    sh = 6'h00;
    clr(1);
    chk(oe, 8'h00);
    zc = 6'h04;
    ov = 1;
    w(6);
    chk(se, 8'h00);
    chk(oe, 8'h01);
    chk(bst, 8'h00);
    ov = 0;
    zc = 6'h00;
    clr(1);
    chk(se, 8'h3F);
    ss = 1;
    rg = 6'h3D;
    ov = 1;
    w(6);
    chk(se, 8'h00);
    chk(oe, 8'h01);
    ov = 0;
    ovr = 1;
    ss = 0;
    rg = 6'h3F;
    w(8);
    chk(oe, 8'h01);
    chk(bst, 8'h00);
    ovr = 0;
    $display("t_group done");
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst(0);
    t_short;
    t_unarmed;
    t_ov_cl;
    t_ov_ss;
    t_group;
    print_verdict;
  end
  // the tests need about 540 cycles; the limit allows 2500
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
endmodule
bind led_driver_fault_manager led_driver_fault_manager_props
  #(.RESET_HOLD(RESET_HOLD)) props_i (.clk, .sys_rst, .group_mode_strap,
  .enable_pin, .dim_pin, .string_short_threshold, .sink_in_regulation,
  .overvoltage_sense, .overvoltage_released, .current_limit_sense,
  .fault_line_out, .fault_line_oe, .boost_enable, .on_time_end);
